/* hw/motor_restart_sequencer.sv */
// Flying restart and automatic restart sequencer with APB registers
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "motor_restart_defs.svh"
module motor_restart_sequencer import motor_restart_pkg::*; #(
  parameter int TICK_CYCLES = (`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int SUCCESS_TICKS = `SUCCESS_S * `TICKS_PER_S
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire apb_req_t apb_req_i,
  output apb_rsp_t apb_rsp_o,
  input wire logic run_command_i,
  input wire logic search_enable_src_i,
  input wire logic setpoint_dir_i,
  input wire logic fault_i,
  input wire logic dc_link_undervoltage_fault_i,
  input wire logic speed_match_i,
  input wire logic magnetizing_done_flag_i,
  input wire logic [15:0] magnetizing_current_ref_i,
  output logic motor_on_o,
  output logic rfg_enable_o,
  output logic search_active_o,
  output logic search_both_dir_o,
  output logic search_dir_o,
  output logic [15:0] search_current_o,
  output logic freq_step_o,
  output logic fault_ack_o,
  output logic restart_failed_fault_o
);
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic counts_mode(input logic [4:0] m);
    return m == `ARM_PF || m == `ARM_FLT || m == `ARM_PF_MAN ||
           m == `ARM_FLT_MAN || m == `ARM_ALL;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == `OFF_MODE || a == `OFF_EXC || a == `OFF_DEEXC || a == `OFF_SEARCH ||
           a == `OFF_ATTEMPT || a == `OFF_WATCH || a == `OFF_STATUS || a == `OFF_CMD;
  endfunction

  seq_state_t state;
  seq_state_t next_state;
  logic [2:0] search_mode_sel;
  logic [4:0] auto_restart_mode;
  logic reluctance_motor;
  logic [15:0] excitation_buildup_time;
  logic [15:0] deexcitation_time;
  logic [7:0] search_current_level;
  logic [7:0] search_speed_factor;
  logic [3:0] start_attempt_max;
  logic [15:0] restart_watch_time;
  logic [3:0] att_cnt;
  logic [TW-1:0] tick_cnt;
  logic tick;
  logic [7:0] step_cnt;
  logic run_cmd;
  logic search_en;
  logic pf_kind;
  logic man_seen;
  logic acked;
  logic watch_run;
  logic man_ack;
  logic cfg_wr;
  logic acc;
  logic wr;
  logic [31:0] rd_val;
  logic wait_load;
  logic wait_done;
  logic watch_done;
  logic succ_done;
  logic fault_evt;
  logic auto_allow;
  logic auto_ack;
  logic any_ack;
  logic restart_ok;
  logic fly_ok;
  logic success;
  logic fail_set;
  logic fail_clr;
  logic [23:0] cur_prod;

  // ----------------------------------------
  // Pin inputs and shared timebase
  // ----------------------------------------
  pin_sync u_sync_run (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(run_command_i),
    .level_o(run_cmd)
  );

  pin_sync u_sync_en (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(search_enable_src_i),
    .level_o(search_en)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || tick_cnt == TW'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TW'(1);
    end
  end

  assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

  // ----------------------------------------
  // APB slave, one wait state per access
  // ----------------------------------------
  assign acc = apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready;
  assign wr = acc && apb_req_i.pwrite;
  assign man_ack = wr && apb_req_i.paddr == `OFF_CMD && apb_req_i.pwdata[`F_CMD_ACK];
  assign cfg_wr = wr && (apb_req_i.paddr == `OFF_MODE || apb_req_i.paddr == `OFF_ATTEMPT);

  always_comb begin
    rd_val = 32'h0000_0000;
    case (apb_req_i.paddr)
      `OFF_MODE: begin
        rd_val[`F_SRCH +: 3] = search_mode_sel;
        rd_val[`F_ARM +: 5] = auto_restart_mode;
        rd_val[`F_RELUCT] = reluctance_motor;
      end
      `OFF_EXC: rd_val[15:0] = excitation_buildup_time;
      `OFF_DEEXC: rd_val[15:0] = deexcitation_time;
      `OFF_SEARCH: begin
        rd_val[`F_CUR +: 8] = search_current_level;
        rd_val[`F_FAC +: 8] = search_speed_factor;
      end
      `OFF_ATTEMPT: rd_val[3:0] = start_attempt_max;
      `OFF_WATCH: rd_val[15:0] = restart_watch_time;
      `OFF_STATUS: begin
        rd_val[`F_ST_STATE +: 3] = state;
        rd_val[`F_ST_ATT +: 4] = att_cnt;
        rd_val[`F_ST_FAIL] = restart_failed_fault_o;
        rd_val[`F_ST_WATCH] = watch_run;
        rd_val[`F_ST_PF] = pf_kind;
        rd_val[`F_ST_RUN] = run_cmd;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      apb_rsp_o <= '0;
    end else begin
      apb_rsp_o.pready <= apb_req_i.psel && apb_req_i.penable && !apb_rsp_o.pready;
      apb_rsp_o.pslverr <= apb_req_i.psel && apb_req_i.penable && !apb_rsp_o.pready &&
                           !mapped(apb_req_i.paddr);
      apb_rsp_o.prdata <= (apb_req_i.pwrite || apb_rsp_o.pready) ? 32'h0000_0000 : rd_val;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      search_mode_sel <= `SRCH_OFF;
      auto_restart_mode <= `ARM_OFF;
      reluctance_motor <= 1'b0;
      excitation_buildup_time <= 16'h0000;
      deexcitation_time <= 16'h0000;
      search_current_level <= `RST_CUR;
      search_speed_factor <= 8'h00;
      start_attempt_max <= `RST_ATT;
      restart_watch_time <= 16'(`WATCH_DEF_S * `TICKS_PER_S);
    end else if (wr) begin
      case (apb_req_i.paddr)
        `OFF_MODE: begin
          search_mode_sel <= apb_req_i.pwdata[`F_SRCH +: 3];
          auto_restart_mode <= apb_req_i.pwdata[`F_ARM +: 5];
          reluctance_motor <= apb_req_i.pwdata[`F_RELUCT];
        end
        `OFF_EXC: excitation_buildup_time <= apb_req_i.pwdata[15:0];
        `OFF_DEEXC: deexcitation_time <= apb_req_i.pwdata[15:0];
        `OFF_SEARCH: begin
          search_current_level <= apb_req_i.pwdata[`F_CUR +: 8];
          search_speed_factor <= apb_req_i.pwdata[`F_FAC +: 8];
        end
        `OFF_ATTEMPT: start_attempt_max <= apb_req_i.pwdata[3:0];
        `OFF_WATCH: restart_watch_time <= apb_req_i.pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  // Excitation and de-excitation never overlap, so they share one counter
  assign wait_load = (next_state != state) &&
                     (next_state == ST_EXCITE || next_state == ST_DEEXC);

  tick_timer #(.W(16)) u_wait (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .load_i(wait_load),
    .value_i(next_state == ST_EXCITE ? excitation_buildup_time : deexcitation_time),
    .done_o(wait_done)
  );

  tick_timer #(.W(16)) u_watch (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .load_i(fault_evt),
    .value_i(restart_watch_time),
    .done_o(watch_done)
  );

  tick_timer #(.W(16)) u_success (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .load_i(state != ST_RUN || !magnetizing_done_flag_i || fault_i),
    .value_i(16'(SUCCESS_TICKS)),
    .done_o(succ_done)
  );

  // ----------------------------------------
  // Fault handling and restart decision
  // ----------------------------------------
  assign fault_evt = next_state == ST_FAULT && state != ST_FAULT;
  assign success = watch_run && succ_done;

  always_comb begin
    unique case (auto_restart_mode)
      `ARM_ACK, `ARM_ALL: auto_allow = 1'b1;
      `ARM_PF, `ARM_FLT: auto_allow = run_cmd;
      default: auto_allow = 1'b0;
    endcase
  end

  assign auto_ack = state == ST_FAULT && fault_i && !acked && auto_allow &&
                    !restart_failed_fault_o &&
                    (auto_restart_mode == `ARM_ACK || att_cnt != 4'h0);
  assign any_ack = auto_ack || (man_ack && fault_i && !acked);

  always_comb begin
    unique case (auto_restart_mode)
      `ARM_PF: restart_ok = pf_kind;
      `ARM_FLT, `ARM_ALL: restart_ok = 1'b1;
      `ARM_PF_MAN: restart_ok = pf_kind && man_seen;
      `ARM_FLT_MAN: restart_ok = man_seen;
      default: restart_ok = 1'b0;
    endcase
  end

  assign fail_set = counts_mode(auto_restart_mode) &&
                    ((state == ST_FAULT && fault_i && !acked && att_cnt == 4'h0) ||
                     (watch_run && watch_done));
  assign fail_clr = man_ack && !run_cmd;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pf_kind <= 1'b1;
    end else if (fault_evt) begin
      pf_kind <= dc_link_undervoltage_fault_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state != ST_FAULT) begin
      man_seen <= 1'b0;
      acked <= 1'b0;
    end else begin
      if (man_ack) begin
        man_seen <= 1'b1;
      end
      if (any_ack) begin
        acked <= 1'b1;
      end else if (!fault_i) begin
        acked <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fault_ack_o <= 1'b0;
    end else begin
      fault_ack_o <= any_ack;
    end
  end

  // Counter never loads below one so a zero setting still allows one try
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || cfg_wr || success || (fail_clr && restart_failed_fault_o)) begin
      att_cnt <= (start_attempt_max == 4'h0) ? 4'h1 : start_attempt_max;
    end else if (any_ack && counts_mode(auto_restart_mode) && att_cnt != 4'h0) begin
      att_cnt <= att_cnt - 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      restart_failed_fault_o <= 1'b0;
    end else if (fail_set) begin
      restart_failed_fault_o <= 1'b1;
    end else if (fail_clr) begin
      restart_failed_fault_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      watch_run <= 1'b0;
    end else if (fault_evt && counts_mode(auto_restart_mode) &&
                 restart_watch_time != 16'h0000) begin
      watch_run <= 1'b1;
    end else if (success || watch_done || restart_failed_fault_o) begin
      watch_run <= 1'b0;
    end
  end

  // ----------------------------------------
  // Switch-on sequence
  // ----------------------------------------
  assign fly_ok = search_mode_sel != `SRCH_OFF && search_en;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_OFF: begin
        if (fault_i) begin
          next_state = ST_FAULT;
        end else if (run_cmd && !restart_failed_fault_o) begin
          next_state = fly_ok ? ST_SEARCH : ST_EXCITE;
        end
      end
      ST_SEARCH: begin
        if (fault_i) begin
          next_state = ST_FAULT;
        end else if (!run_cmd) begin
          next_state = ST_DEEXC;
        end else if (speed_match_i) begin
          next_state = ST_EXCITE;
        end
      end
      ST_EXCITE: begin
        if (fault_i) begin
          next_state = ST_FAULT;
        end else if (!run_cmd) begin
          next_state = ST_DEEXC;
        end else if (wait_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fault_i) begin
          next_state = ST_FAULT;
        end else if (!run_cmd) begin
          next_state = reluctance_motor ? ST_OFF : ST_DEEXC;
        end
      end
      ST_DEEXC: begin
        if (wait_done || reluctance_motor) begin
          next_state = ST_OFF;
        end
      end
      ST_FAULT: begin
        if (!fault_i) begin
          if (restart_ok && run_cmd && !restart_failed_fault_o) begin
            next_state = ST_DEEXC;
          end else begin
            next_state = ST_LOCK;
          end
        end
      end
      ST_LOCK: begin
        if (!run_cmd) begin
          next_state = ST_OFF;
        end
      end
      default: next_state = ST_LOCK;
    endcase
  end

  // Reset enters the fault state so power-up is judged like a power failure
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= ST_FAULT;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Drive outputs
  // ----------------------------------------
  assign cur_prod = magnetizing_current_ref_i * {16'h0000, search_current_level};

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      motor_on_o <= 1'b0;
      rfg_enable_o <= 1'b0;
      search_active_o <= 1'b0;
      search_both_dir_o <= 1'b0;
      search_dir_o <= 1'b0;
      search_current_o <= 16'h0000;
    end else begin
      motor_on_o <= next_state == ST_SEARCH || next_state == ST_EXCITE ||
                    next_state == ST_RUN;
      rfg_enable_o <= next_state == ST_RUN;
      search_active_o <= next_state == ST_SEARCH;
      search_both_dir_o <= search_mode_sel == `SRCH_BOTH;
      search_dir_o <= setpoint_dir_i;
      search_current_o <= (next_state == ST_SEARCH) ? cur_prod[23:8] : 16'h0000;
    end
  end

  // One frequency step every factor+1 ticks: bigger factor, slower sweep
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state != ST_SEARCH) begin
      step_cnt <= 8'h00;
      freq_step_o <= 1'b0;
    end else begin
      freq_step_o <= tick && step_cnt == search_speed_factor;
      if (tick) begin
        step_cnt <= (step_cnt == search_speed_factor) ? 8'h00 : step_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_no_search_off: assert property ($rose(state == ST_SEARCH) |->
    $past(search_mode_sel) != `SRCH_OFF && $past(search_en))
    else $error("search entered while flying restart is off");
  a_search_dir: assert property (search_active_o && $past(search_mode_sel) == `SRCH_SETP
    |-> !search_both_dir_o) else $error("both-way search in setpoint mode");
  a_exc_wait: assert property ($rose(state == ST_RUN) |->
    $past(state) == ST_EXCITE && $past(wait_done)) else $error("ramp enabled early");
  a_deexc_block: assert property (state == ST_DEEXC |-> !motor_on_o ##1 !motor_on_o)
    else $error("motor on during de-excitation");
  a_reluct_skip: assert property (state == ST_RUN && !run_cmd && !fault_i &&
    reluctance_motor |=> state == ST_OFF) else $error("reluctance motor waited");
  a_ack_never: assert property ((auto_restart_mode == `ARM_PF_MAN ||
    auto_restart_mode == `ARM_FLT_MAN) && !man_ack |=> !fault_ack_o)
    else $error("automatic acknowledge in manual mode");
  a_ack_run: assert property (fault_ack_o && !$past(man_ack) &&
    ($past(auto_restart_mode) == `ARM_PF || $past(auto_restart_mode) == `ARM_FLT)
    |-> $past(run_cmd)) else $error("acknowledge without run command");
  a_mode1_stay: assert property (state == ST_FAULT && auto_restart_mode == `ARM_ACK
    |=> state != ST_DEEXC) else $error("mode 1 restarted the motor");
  a_watch_fail: assert property (watch_run && watch_done &&
    counts_mode(auto_restart_mode) |=> restart_failed_fault_o)
    else $error("watch expiry missed");
  a_ack_count: assert property (fault_ack_o && counts_mode($past(auto_restart_mode))
    && $past(att_cnt) != 4'h0 && !$past(cfg_wr) && !$past(success) && !$past(fail_clr)
    |-> att_cnt == $past(att_cnt) - 4'h1) else $error("attempt count not decremented");

  c_search: cover property (state == ST_SEARCH ##[1:1000] state == ST_RUN);
  c_success: cover property (success);
  c_failed: cover property ($rose(restart_failed_fault_o));
endmodule

/* include/motor_restart_defs.svh */
// Constants of the motor restart sequencer: offsets, fields, reset values, times
// Notes on behaviour
// - Search mode 0: never search at switch-on
// - Search mode 1: search both directions
// - Search mode 4: search setpoint direction only
// - Wait excitation time before ramp enable
// - Block switch-on until de-excitation time elapses
// - Reluctance motor skips the de-excitation wait
// - Flying restart only while enable source true
// - Search current is fraction of magnetizing current
// - Larger search factor slows the frequency sweep
// - DC-link undervoltage counts as power failure
// - Full supply loss counts as power failure
// - Modes 1 and 26 always acknowledge faults; mode 26 here stops once the attempt counter is exhausted
// - Modes 4, 6 acknowledge only with run command
// - Modes 14, 16 never acknowledge automatically
// - Restart needs run command; mode 1 never
// - Success: no fault one second after magnetizing
// - Mode 0 nothing; mode 1 acknowledge only
// - Mode 4 after power failure, 6 any fault
// - Modes 14, 16 restart after manual acknowledgement
// - Mode 26 acknowledges all and restarts
// - Search, match speed, excite, then accelerate
// - Attempt counter default 3, exhausted raises fault
// - Watch timer from fault, default 60 s
`ifndef MOTOR_RESTART_DEFS_SVH
`define MOTOR_RESTART_DEFS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFF_MODE 8'h00
`define OFF_EXC 8'h04
`define OFF_DEEXC 8'h08
`define OFF_SEARCH 8'h0C
`define OFF_ATTEMPT 8'h10
`define OFF_WATCH 8'h14
`define OFF_STATUS 8'h18
`define OFF_CMD 8'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define F_SRCH 0
`define F_ARM 8
`define F_RELUCT 16
`define F_CUR 0
`define F_FAC 8
`define F_ST_STATE 0
`define F_ST_ATT 8
`define F_ST_FAIL 16
`define F_ST_WATCH 17
`define F_ST_PF 18
`define F_ST_RUN 19
`define F_CMD_ACK 0

// ----------------------------------------
// Mode encodings
// ----------------------------------------
`define SRCH_OFF 3'h0
`define SRCH_BOTH 3'h1
`define SRCH_SETP 3'h4
`define ARM_OFF 5'h00
`define ARM_ACK 5'h01
`define ARM_PF 5'h04
`define ARM_FLT 5'h06
`define ARM_PF_MAN 5'h0E
`define ARM_FLT_MAN 5'h10
`define ARM_ALL 5'h1A

// ----------------------------------------
// Reset values and times
// ----------------------------------------
`define RST_ATT 4'h3
`define RST_CUR 8'h80
`define CLK_PERIOD_NS 20
`define TICK_NS 1000000
`define TICKS_PER_S (1000000000 / `TICK_NS)
`define SUCCESS_S 1
`define WATCH_DEF_S 60

`endif

/* include/motor_restart_pkg.sv */
// Types shared by the motor restart sequencer
package motor_restart_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_SEARCH = 3'b001,
    ST_EXCITE = 3'b010,
    ST_RUN = 3'b011,
    ST_DEEXC = 3'b100,
    ST_FAULT = 3'b101,
    ST_LOCK = 3'b110
  } seq_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_t;
endpackage

/* hw/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once the last two stages agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      level_o <= 1'b0;
    end else if (s2 == s3) begin
      level_o <= s3;
    end
  end
endmodule

/* hw/tick_timer.sv */
// Loadable down-counter stepped by the shared tick
`timescale 1ns/100ps
module tick_timer #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o
);
  localparam logic [W:0] ONE = {{W{1'b0}}, 1'b1};

  // One spare count so a partly elapsed first tick never shortens a wait
  logic [W:0] count;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= (value_i == '0) ? '0 : {1'b0, value_i} + ONE;
    end else if (tick_i && count != '0) begin
      count <= count - ONE;
    end
  end

  assign done_o = (count == '0) && !load_i;
endmodule

/* verif/motor_core_model.sv */
// Behavioural model of the motor control core beside the sequencer
`timescale 1ns/100ps
module motor_core_model (
  input wire logic clk_i,
  input wire logic inject_i,
  input wire logic search_active_i,
  input wire logic motor_on_i,
  input wire logic fault_ack_i,
  output logic fault_o,
  output logic speed_match_o,
  output logic mag_done_o
);
  int srch_cnt = 0;
  initial begin
    fault_o = 1'b0;
    speed_match_o = 1'b0;
    mag_done_o = 1'b0;
  end
  // Fault stays pending until acknowledged, as a real core would hold it
  always @(posedge clk_i) begin
    if (inject_i) fault_o <= 1'b1;
    else if (fault_ack_i) fault_o <= 1'b0;
    srch_cnt <= search_active_i ? srch_cnt + 1 : 0;
    speed_match_o <= search_active_i && srch_cnt >= 6;
    mag_done_o <= motor_on_i && !search_active_i;
  end
endmodule

/* verif/motor_restart_sequencer_tb.sv */
// Self-checking bench of the motor restart sequencer
`timescale 1ns/100ps
module motor_restart_sequencer_tb import motor_restart_pkg::*;;
  localparam int TC = 4;
  localparam int EXC = 3;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic run = 1'b0, en = 1'b1, dir = 1'b0, inject = 1'b0, uv = 1'b1;
  logic [15:0] magref = 16'h0000;
  logic [15:0] scur, gc;
  logic fault, match, mdone, motor_on, rfg, srch, both, sdir, ack, failed, fstep;
  logic gb, gd, e;
  logic [31:0] q;
  int err_count = 0;
  int checks = 0;
  int seed = 32'h907e;
  int saw, excn, lvl, steps;

  motor_restart_sequencer #(.TICK_CYCLES(TC), .SUCCESS_TICKS(5)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .run_command_i(run), .search_enable_src_i(en), .setpoint_dir_i(dir),
    .fault_i(fault), .dc_link_undervoltage_fault_i(uv), .speed_match_i(match),
    .magnetizing_done_flag_i(mdone), .magnetizing_current_ref_i(magref),
    .motor_on_o(motor_on), .rfg_enable_o(rfg), .search_active_o(srch),
    .search_both_dir_o(both), .search_dir_o(sdir), .search_current_o(scur),
    .freq_step_o(fstep), .fault_ack_o(ack), .restart_failed_fault_o(failed));

  motor_core_model core (.clk_i(clk_i), .inject_i(inject), .search_active_i(srch),
    .motor_on_i(motor_on), .fault_ack_i(ack), .fault_o(fault), .speed_match_o(match),
    .mag_done_o(mdone));

  initial forever #10 clk_i = ~clk_i;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic hang;
    err_count++;
    $display("unexpected at %0t: wait ran out", $time);
    final_report();
  endtask

  // Request held until pready is seen at an edge, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    if (n >= 20) hang();
  endtask

  task automatic start;
    int n;
    n = 0;
    saw = 0;
    excn = 0;
    steps = 0;
    run <= 1'b1;
    while (rfg !== 1'b1 && n < 500) begin
      @(posedge clk_i);
      n++;
      if (fstep === 1'b1) steps++;
      if (srch === 1'b1) begin
        saw = 1;
        gb = both;
        gd = sdir;
        gc = scur;
      end
      if (motor_on === 1'b1 && srch !== 1'b1 && rfg !== 1'b1) excn++;
    end
    if (n >= 500) hang();
  endtask

  task automatic stop;
    run <= 1'b0;
    repeat (30) @(posedge clk_i);
    apb(1'b1, 8'h1c, 32'h0000_0001);
    repeat (60) @(posedge clk_i);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk(q[2:0], 0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int sm[4];
    int se[4];
    int am[7];
    int acks;
    sm = '{0, 1, 4, 1};
    se = '{1, 1, 1, 0};
    am = '{0, 1, 4, 6, 26, 16, 4};
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(q, 32'h0000_0003);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(q, 32'h0000_ea60);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(q, 32'h0000_0080);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk(e, 1);
    $display("register test done");
    apb(1'b1, 8'h04, EXC);
    for (int i = 0; i < 4; i++) begin
      dir <= 1'($random(seed));
      magref <= 16'($random(seed));
      en <= se[i][0];
      lvl = $random(seed) & 255;
      apb(1'b1, 8'h0c, lvl);
      apb(1'b1, 8'h00, sm[i]);
      start();
      chk(saw, sm[i] != 0 && se[i] != 0);
      chk(steps != 0 && steps <= 3, saw != 0);
      if (saw != 0) begin
        chk(gb, sm[i] == 1);
        chk(gc, (int'(magref) * lvl) >> 8);
        chk(gd, dir);
      end
      chk(excn >= EXC * TC - 1 && excn <= (EXC + 1) * TC + 3, 1);
      stop();
      $display("search test %0d done", i);
    end
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, 8'h00, am[i] << 8);
      start();
      uv <= i != 6;
      inject <= 1'b1;
      @(posedge clk_i);
      inject <= 1'b0;
      acks = 0;
      repeat (300) begin
        @(posedge clk_i);
        if (ack === 1'b1) acks++;
      end
      chk(acks, am[i] != 0 && am[i] != 16);
      chk(motor_on, am[i] > 1 && am[i] != 16 && i != 6);
      chk(failed, 0);
      apb(1'b0, 8'h18, 32'h0000_0000);
      chk(q[17], am[i] == 16 || i == 6);
      chk(q[11:8], 3 - (i == 6));
      stop();
      $display("restart test %0d done", i);
    end
    apb(1'b1, 8'h00, 32'h0000_0600);
    apb(1'b1, 8'h14, 32'h0000_0002);
    inject <= 1'b1;
    @(posedge clk_i);
    inject <= 1'b0;
    acks = 0;
    repeat (100) begin
      @(posedge clk_i);
      if (ack === 1'b1) acks++;
    end
    chk(acks, 0);
    chk(failed, 1);
    stop();
    chk(failed, 0);
    $display("run low test done");
    final_report();
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    hang();
  end
endmodule
